/* sfp_consts.svh */
// constants of the stepper fault protection and reset sequencing pair
// assumes a single 10 MHz clock (mclk) shared by both ends
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH

`define SFP_CLK_NS 100
`define SFP_BLANK_NS 1250
`define SFP_BLANK_CYC ((`SFP_BLANK_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_PWM_PERIOD_NS 20833
`define SFP_PWM_CYC (`SFP_PWM_PERIOD_NS / `SFP_CLK_NS)
`define SFP_DEAD_NS 1250
`define SFP_DEAD_CYC ((`SFP_DEAD_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_STEP_WAIT_NS 10000
`define SFP_STEP_WAIT_CYC ((`SFP_STEP_WAIT_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_RST_PULSE_CYC 2
`define SFP_PHASE_OFF 4'h0

`endif

/* sfp_pkg.sv */
// types shared by the device end, the controller end and their interface
// assumes sfp_consts.svh for all figures
package sfp_pkg;

	// three-level fault output plus the idle level
	typedef enum logic [1:0] {
		SFP_KIND_NONE = 2'h0,
		SFP_KIND_OPEN = 2'h1,
		SFP_KIND_OVERCUR = 2'h2,
		SFP_KIND_OVERHEAT = 2'h3
	} sfp_kind_t;

	typedef enum logic [1:0] {
		SFP_H_RST_LOW,
		SFP_H_RST_WAIT,
		SFP_H_RUN
	} sfp_hstate_t;

	typedef struct packed {
		sfp_kind_t kind;
		logic [7:0] pwm_cnt;
		logic [3:0] dead_cnt;
		logic switch_on;
		logic chopping;
		logic off_armed;
		logic flyback_hit;
		logic en_q;
		logic step_q;
		logic step_evt;
		logic [3:0] phase_out;
	} sfp_dev_t;

	typedef struct packed {
		sfp_hstate_t state;
		logic [7:0] cnt;
		logic enable;
		logic rst_n;
		logic step_clk;
		logic fault_seen;
		sfp_kind_t kind_seen;
	} sfp_host_t;

endpackage

/* sfp_if.sv */
// link between the motor controller and the protected driver
// the any-fault line is open drain with a pull-up, resolved here
`timescale 1ns/1ps
interface sfp_if;
	logic enable;
	logic system_reset_n;
	logic step_clk;
	logic any_fault_o;
	logic any_fault_oe;
	wire any_fault_n;
	sfp_pkg::sfp_kind_t fault_kind_level;

	// pull-up when nobody drives the flag
	assign any_fault_n = any_fault_oe ? any_fault_o : 1'b1;

	modport dev (
		input enable,
		input system_reset_n,
		input step_clk,
		output any_fault_o,
		output any_fault_oe,
		output fault_kind_level
	);

	modport host (
		output enable,
		output system_reset_n,
		output step_clk,
		input any_fault_n,
		input fault_kind_level
	);
endinterface

/* sfp_device.sv */
// protected driver end: pwm timing, current-sense blanking, fault latches
// drive stays off while enable is low or any fault is latched
// assumes analog comparators arrive as synchronous levels on mclk
`timescale 1ns/1ps
`include "sfp_consts.svh"

module sfp_device (
	// clock and power-on reset
	input wire logic mclk,
	input wire logic reset_n,

	// controller link
	sfp_if.dev lnk,

	// analog comparator levels
	input wire logic cur_over_set,
	input wire logic cur_over_limit,
	input wire logic cur_ge_min,
	input wire logic flyback_seen,
	input wire logic overheat,

	// phase requests from the excitation sequencer
	input wire logic [3:0] phase_req,

	// drive and status
	output logic [3:0] phase_out,
	output logic switch_on,
	output logic step_evt,
	output logic fault_latched
);

	////////////////////////////////////////////////////////////////////////
	// constants at the width of the counters

	// windows round up so blanking and dead time never end early
	localparam logic [7:0] PWM_LAST = 8'(`SFP_PWM_CYC - 1);
	localparam logic [7:0] BLANK_CYC = 8'(`SFP_BLANK_CYC);
	localparam logic [3:0] DEAD_CYC = 4'(`SFP_DEAD_CYC);

	////////////////////////////////////////////////////////////////////////
	// state

	sfp_pkg::sfp_dev_t st_r;
	sfp_pkg::sfp_dev_t st_nxt;

	logic faulted;
	logic blank_active;
	logic period_end;
	sfp_pkg::sfp_kind_t new_kind;
	logic oc_armed;
	logic open_miss;
	logic step_rise;
	logic chop_now;

	assign faulted = (st_r.kind != sfp_pkg::SFP_KIND_NONE);
	assign period_end = (st_r.pwm_cnt == PWM_LAST);

	assign blank_active = st_r.chopping && (st_r.pwm_cnt < BLANK_CYC);

	////////////////////////////////////////////////////////////////////////
	// qualified events

	// limit compare live once dead time has run out
	assign oc_armed = (st_r.dead_cnt == DEAD_CYC);

	// armed off time ended without any flyback
	assign open_miss = period_end && st_r.off_armed && !st_r.flyback_hit &&
		!flyback_seen;

	// step edge detector idles low like the pin, no false step after reset
	assign step_rise = lnk.step_clk && !st_r.step_q;

	// first rise is never blanked, a spike there chops early
	assign chop_now = st_r.switch_on && cur_over_set && !blank_active;

	////////////////////////////////////////////////////////////////////////
	// fault detection, first fault wins its kind
	// same-cycle priority: overheat, then overcurrent, then open

	always_comb begin
		new_kind = sfp_pkg::SFP_KIND_NONE;
		// overheat needs no current window, it guards the substrate
		if (overheat) begin
			new_kind = sfp_pkg::SFP_KIND_OVERHEAT;
		end else if (cur_over_limit && oc_armed) begin
			new_kind = sfp_pkg::SFP_KIND_OVERCUR;
		end else if (open_miss) begin
			new_kind = sfp_pkg::SFP_KIND_OPEN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_nxt = st_r;
		st_nxt.step_evt = 1'b0;
		st_nxt.en_q = lnk.enable;
		st_nxt.step_q = lnk.step_clk;

		if (!lnk.system_reset_n) begin
			// reset pin low clears the latch
			st_nxt.kind = sfp_pkg::SFP_KIND_NONE;
			st_nxt.pwm_cnt = 8'h00;
			st_nxt.dead_cnt = 4'h0;
			st_nxt.switch_on = 1'b0;
			st_nxt.chopping = 1'b0;
			st_nxt.off_armed = 1'b0;
			st_nxt.flyback_hit = 1'b0;
			st_nxt.en_q = 1'b0;
			st_nxt.phase_out = `SFP_PHASE_OFF;
		end else if (!lnk.enable) begin
			// internal clock stopped, inputs ignored
			// counters freeze; the next enable rise restarts the period
			st_nxt.switch_on = 1'b0;
			st_nxt.phase_out = `SFP_PHASE_OFF;
		end else if (faulted) begin
			st_nxt.switch_on = 1'b0;
			st_nxt.phase_out = `SFP_PHASE_OFF;
		end else if (!st_r.en_q) begin
			// enable just rose: fresh current rise, no chopping yet
			st_nxt.pwm_cnt = 8'h00;
			st_nxt.dead_cnt = 4'h0;
			st_nxt.switch_on = 1'b1;
			st_nxt.chopping = 1'b0;
			st_nxt.off_armed = 1'b0;
			st_nxt.flyback_hit = 1'b0;
			st_nxt.phase_out = phase_req;
		end else begin
			if (st_r.dead_cnt != DEAD_CYC) begin
				st_nxt.dead_cnt = st_r.dead_cnt + 4'h1;
			end

			if (step_rise) begin
				st_nxt.step_evt = 1'b1;
			end

			if (!st_r.switch_on && flyback_seen) begin
				st_nxt.flyback_hit = 1'b1;
			end

			if (period_end) begin
				// new period: switch back on, open check restarts
				st_nxt.pwm_cnt = 8'h00;
				st_nxt.switch_on = 1'b1;
				st_nxt.off_armed = 1'b0;
				st_nxt.flyback_hit = 1'b0;
			end else begin
				st_nxt.pwm_cnt = st_r.pwm_cnt + 8'h01;
				if (chop_now) begin
					st_nxt.switch_on = 1'b0;
					st_nxt.chopping = 1'b1;
					// open check only if current was high enough
					st_nxt.off_armed = cur_ge_min;
					st_nxt.flyback_hit = 1'b0;
				end
			end

			if (new_kind != sfp_pkg::SFP_KIND_NONE) begin
				// latch the fault, drive off at once
				st_nxt.kind = new_kind;
				st_nxt.switch_on = 1'b0;
				st_nxt.phase_out = `SFP_PHASE_OFF;
			end else begin
				st_nxt.phase_out = st_nxt.switch_on ? phase_req : `SFP_PHASE_OFF;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	// one state register keeps every latch under the same reset
	// power-on reset clears every latch and counter
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// open drain, pulled low on any fault
	assign lnk.any_fault_o = 1'b0;
	assign lnk.any_fault_oe = faulted;

	// kind straight from the latch
	// the controller samples it one edge later
	assign lnk.fault_kind_level = st_r.kind;

	assign phase_out = st_r.phase_out;
	assign switch_on = st_r.switch_on;
	assign step_evt = st_r.step_evt;
	assign fault_latched = faulted;

endmodule

/* sfp_host.sv */
// motor controller end: enable gating, reset pulse, step clock pacing
// assumes a supply monitor level and user requests on mclk
`timescale 1ns/1ps
`include "sfp_consts.svh"

module sfp_host (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,

	// user side
	input wire logic supply_ok,
	input wire logic run_req,
	input wire logic step_req,
	input wire logic clear_req,
	output logic step_ready,
	output logic fault_seen,
	output sfp_pkg::sfp_kind_t fault_kind_seen,

	// driver link
	sfp_if.host lnk
);

	localparam logic [7:0] PULSE_LAST = 8'(`SFP_RST_PULSE_CYC - 1);
	localparam logic [7:0] WAIT_LAST = 8'(`SFP_STEP_WAIT_CYC - 1);

	sfp_pkg::sfp_host_t st_r;
	sfp_pkg::sfp_host_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		// enable only with a good supply
		st_nxt.enable = supply_ok && run_req;
		st_nxt.fault_seen = !lnk.any_fault_n;
		st_nxt.kind_seen = lnk.fault_kind_level;
		case (st_r.state)
			sfp_pkg::SFP_H_RST_LOW: begin
				// low phase of the clearing pulse
				st_nxt.rst_n = 1'b0;
				st_nxt.cnt = st_r.cnt + 8'h01;
				if (st_r.cnt == PULSE_LAST) begin
					st_nxt.rst_n = 1'b1;
					st_nxt.cnt = 8'h00;
					st_nxt.state = sfp_pkg::SFP_H_RST_WAIT;
				end
			end
			sfp_pkg::SFP_H_RST_WAIT: begin
				st_nxt.cnt = st_r.cnt + 8'h01;
				if (st_r.cnt == WAIT_LAST) begin
					st_nxt.state = sfp_pkg::SFP_H_RUN;
				end
			end
			default: begin
				if (clear_req) begin
					st_nxt.rst_n = 1'b0;
					st_nxt.cnt = 8'h00;
					st_nxt.state = sfp_pkg::SFP_H_RST_LOW;
				end else if (step_req) begin
					st_nxt.step_clk = !st_r.step_clk;
				end
			end
		endcase
	end

	// reset starts with a full clearing pulse
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{state: sfp_pkg::SFP_H_RST_LOW, cnt: 8'h00, enable: 1'b0,
				rst_n: 1'b0, step_clk: 1'b0, fault_seen: 1'b0,
				kind_seen: sfp_pkg::SFP_KIND_NONE};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign lnk.enable = st_r.enable;
	assign lnk.system_reset_n = st_r.rst_n;
	assign lnk.step_clk = st_r.step_clk;
	assign step_ready = (st_r.state == sfp_pkg::SFP_H_RUN);
	assign fault_seen = st_r.fault_seen;
	assign fault_kind_seen = st_r.kind_seen;

endmodule

/* sfp_asserts.sv */
// link checker for the stepper fault protection pair
// assumes one mclk domain, instantiated beside sfp_if
`timescale 1ns/1ps
module sfp_asserts (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// link
	input wire logic enable,
	input wire logic system_reset_n,
	input wire logic step_clk,
	input wire logic any_fault_o,
	input wire logic any_fault_oe,
	input wire logic any_fault_n,
	input wire sfp_pkg::sfp_kind_t fault_kind_level
);
	default clocking
		@(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	// cycles since the reset pin went high, saturating
	logic [6:0] quiet_r;
	logic [6:0] quiet_nxt;
	always_comb begin
		quiet_nxt = quiet_r;
		if (!system_reset_n)
			quiet_nxt = 7'h0;
		else if (quiet_r != 7'h7f)
			quiet_nxt = quiet_r + 7'h1;
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			quiet_r <= 7'h0;
		else
			quiet_r <= quiet_nxt;
	end
	////////////////////////////////////////
	flag_with_kind_a: assert property (fault_kind_level != 2'h0 |-> !any_fault_n)
		else $error("flag high with a fault kind");
	drain_low_a: assert property (any_fault_oe |-> !any_fault_o)
		else $error("flag driven high");
	kind_held_a: assert property (fault_kind_level != 2'h0 && system_reset_n |=> $stable(fault_kind_level))
		else $error("latched kind changed");
	pin_clears_a: assert property (!system_reset_n |=> fault_kind_level == 2'h0 && !any_fault_oe)
		else $error("reset pin did not clear");
	idle_frozen_a: assert property (!enable && system_reset_n |=> $stable(fault_kind_level))
		else $error("fault latched while idle");
	// a flag raised with enable low would mean inputs leak past the stopped clock
	raise_enabled_a: assert property ($rose(any_fault_oe) |-> $past(enable) && $past(system_reset_n))
		else $error("flag rose without enable");
	pulse_two_a: assert property ($fell(system_reset_n) |=> !system_reset_n ##1 system_reset_n)
		else $error("reset pulse length wrong");
	step_quiet_a: assert property (system_reset_n && quiet_r < 7'h64 |=> $stable(step_clk))
		else $error("step too soon after reset");
	cover property (fault_kind_level == 2'h1);
	cover property (fault_kind_level == 2'h2);
	cover property (fault_kind_level == 2'h3);
	cover property ($fell(system_reset_n));
endmodule

/* test_stepper_fault_protect_seq.sv */
// bench for the protected driver and its controller
// assumes sfp_if joins sfp_device and sfp_host
`timescale 1ns/1ps
module test_stepper_fault_protect_seq;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic cur_over_set, cur_over_limit, cur_ge_min, flyback_seen, overheat;
	logic supply_ok, run_req, step_req, clear_req;
	logic switch_on, step_evt, fault_latched, step_ready, fault_seen;
	logic [3:0] phase_req, phase_out, hits;
	sfp_pkg::sfp_kind_t fault_kind_seen;
	int n_fail = 0;
	int compares = 0;
	always #50 mclk = ~mclk;
	sfp_if lnk ();
	sfp_device u_sfp_device (.mclk(mclk), .reset_n(reset_n), .lnk(lnk),
		.cur_over_set(cur_over_set), .cur_over_limit(cur_over_limit),
		.cur_ge_min(cur_ge_min), .flyback_seen(flyback_seen), .overheat(overheat),
		.phase_req(phase_req), .phase_out(phase_out), .switch_on(switch_on),
		.step_evt(step_evt), .fault_latched(fault_latched));
	sfp_host u_sfp_host (.mclk(mclk), .reset_n(reset_n), .supply_ok(supply_ok),
		.run_req(run_req), .step_req(step_req), .clear_req(clear_req),
		.step_ready(step_ready), .fault_seen(fault_seen),
		.fault_kind_seen(fault_kind_seen), .lnk(lnk));
	sfp_asserts u_sfp_asserts (.mclk(mclk), .reset_n(reset_n), .enable(lnk.enable),
		.system_reset_n(lnk.system_reset_n), .step_clk(lnk.step_clk),
		.any_fault_o(lnk.any_fault_o), .any_fault_oe(lnk.any_fault_oe),
		.any_fault_n(lnk.any_fault_n), .fault_kind_level(lnk.fault_kind_level));
	////////////////////////////////////////
	task automatic wrap_up();
		if (n_fail == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [3:0] e, input logic [3:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// bounded wait on ready or on the switch
	task automatic wait_hi(input bit sw);
		for (int i = 0; i < 400; i++) begin
			if ((sw ? switch_on : step_ready) === 1'b1)
				return;
			tick(1);
		end
		n_fail++;
		wrap_up();
	endtask
	task automatic clr();
		clear_req = 1'b1;
		tick(1);
		clear_req = 1'b0;
		tick(2);
		wait_hi(1'b0);
	endtask
	////////////////////////////////////////
	initial begin
		{cur_over_set, cur_over_limit, cur_ge_min, flyback_seen, overheat} = 5'h0;
		{supply_ok, run_req, step_req, clear_req} = 4'h0;
		phase_req = 4'h5;
		tick(8);
		reset_n = 1'b1;
		run_req = 1'b1;
		tick(3);
		chk("enable", 4'h0, {3'h0, lnk.enable});
		chk("kind", 4'h0, {2'h0, lnk.fault_kind_level});
		supply_ok = 1'b1;
		wait_hi(1'b0);
		chk("phase", 4'h5, phase_out);
		step_req = 1'b1;
		tick(1);
		step_req = 1'b0;
		hits = 4'h0;
		repeat (4) begin
			tick(1);
			hits = hits + {3'h0, step_evt};
		end
		chk("steps", 4'h1, hits);
		overheat = 1'b1;
		tick(1);
		overheat = 1'b0;
		tick(2);
		chk("flag", 4'h0, {3'h0, lnk.any_fault_n});
		chk("kind", 4'h3, {2'h0, lnk.fault_kind_level});
		chk("seen", 4'h3, {2'h0, fault_kind_seen});
		chk("phase", 4'h0, phase_out);
		chk("latched", 4'h1, {3'h0, fault_latched});
		clr();
		chk("flag", 4'h1, {3'h0, lnk.any_fault_n});
		chk("kind", 4'h0, {2'h0, lnk.fault_kind_level});
		chk("latched", 4'h0, {3'h0, fault_latched});
		// overheat while enable is low must be ignored
		run_req = 1'b0;
		tick(2);
		overheat = 1'b1;
		tick(1);
		overheat = 1'b0;
		chk("kind", 4'h0, {2'h0, lnk.fault_kind_level});
		chk("phase", 4'h0, phase_out);
		// limit held from enable rise: ignored in dead time only
		run_req = 1'b1;
		cur_over_limit = 1'b1;
		tick(6);
		chk("kind", 4'h0, {2'h0, lnk.fault_kind_level});
		tick(20);
		chk("kind", 4'h2, {2'h0, lnk.fault_kind_level});
		cur_over_limit = 1'b0;
		clr();
		run_req = 1'b0;
		tick(3);
		{cur_over_set, cur_ge_min, flyback_seen, run_req} = 4'hf;
		tick(5);
		chk("switch", 4'h0, {3'h0, switch_on});
		wait_hi(1'b1);
		for (int i = 0; i < 13; i++) begin
			tick(1);
			chk("switch", 4'h1, {3'h0, switch_on});
		end
		tick(1);
		chk("switch", 4'h0, {3'h0, switch_on});
		tick(217);
		chk("kind", 4'h0, {2'h0, lnk.fault_kind_level});
		flyback_seen = 1'b0;
		tick(450);
		chk("kind", 4'h1, {2'h0, lnk.fault_kind_level});
		chk("seen", 4'h1, {3'h0, fault_seen});
		// below minimum current the open check stays unarmed
		{cur_over_set, cur_ge_min} = 2'h0;
		clr();
		tick(300);
		cur_over_set = 1'b1;
		tick(450);
		chk("kind", 4'h0, {2'h0, lnk.fault_kind_level});
		wrap_up();
	end
endmodule
